/* File: cbm_if.sv */
/*
 Pipelined master/slave bus link between the core bus unit and a slave.
 Assumes one shared clock; the testbench instantiates and connects it.
*/
`timescale 1ns/1ps
interface cbm_if;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [2:0]  hburst;
    logic [3:0]  hbstrb;
    logic        hunalign;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic [2:0]  hresp;

    modport master (
        output haddr, htrans, hwrite, hsize, hburst, hbstrb, hunalign,
               hwdata,
        input  hrdata, hready, hresp
    );
    modport slave (
        input  haddr, htrans, hwrite, hsize, hburst, hbstrb, hunalign,
               hwdata,
        output hrdata, hready, hresp
    );
endinterface : cbm_if

/* File: cbm_master.sv */
/*
 Core bus master: takes requests from a two-entry buffer and issues
 pipelined single or incrementing-burst word transfers on cbm_if.
 Assumes a slave that keeps the two-cycle error response.
*/
//
// Operation
// RULE_01: Burst beats are word, all strobes, aligned flag
// RULE_02: Every burst uses incrementing type only
// RULE_03: Burst starts word aligned, steps one word
// RULE_04: Bursts may have any length, even one
// RULE_05: Burst may end, next transfer follows directly
// RULE_06: Write data follows the address acceptance cycle
// RULE_07: Untaken request may be replaced by another
// RULE_08: Only read requests are ever replaced
// RULE_09: Retracted beat replaced by burst or single
// RULE_10: New request taken only when previous completes
// RULE_11: Request on idle bus taken same cycle
// RULE_12: Slave returns read data next cycle onward
// RULE_13: Error is two cycles, ready low then high
// RULE_14: Second error cycle may change pending request
// RULE_15: Read data ignored on error termination
// RULE_16: After prefetch error, pending request stays
// RULE_17: After data read error, pending goes idle
// RULE_18: After split write first error, abort second
// RULE_19: At most one accepted transfer outstanding
// RULE_20: Idle transfer type during and after reset
`timescale 1ns/1ps
`include "cbm_params.svh"
module cbm_master #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic            clock_i,
    input  wire logic            rst_n_i,
    // Request side
    input  wire logic            req_valid_i,
    output logic                 req_ready_o,
    input  wire cbm_pkg::cbm_req_t req_i,
    input  wire logic            req_last_i,
    // Completion side
    output logic                 done_valid_o,
    output logic [31:0]          done_rdata_o,
    output logic                 done_error_o,
    // Bus
    cbm_if.master                bus
);
    import cbm_pkg::*;

    initial begin
        if (DEPTH != 2) $error("cbm_master: DEPTH must be 2");
    end

    ////////////////////////////////////////////////////////////////////
    // Two-entry request buffer
    cbm_req_t buf_mem [0:1];
    logic     buf_last [0:1];
    logic     wr_ptr_reg, rd_ptr_reg;
    logic [1:0] count_reg;
    logic     buf_valid, buf_pop, buf_push;
    cbm_req_t head;
    logic     head_last;

    assign head        = buf_mem[rd_ptr_reg];
    assign head_last   = buf_last[rd_ptr_reg];
    assign buf_valid   = (count_reg != 2'h0);
    assign req_ready_o = (count_reg != 2'h2);
    assign buf_push    = req_valid_i && req_ready_o;

    always_ff @(posedge clock_i) begin
        if (buf_push) begin
            buf_mem[wr_ptr_reg]  <= req_i;
            buf_last[wr_ptr_reg] <= req_last_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (buf_push) wr_ptr_reg <= ~wr_ptr_reg;
            if (buf_pop)  rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data phase tracking: one outstanding transfer only
    logic        dp_valid_reg;
    logic        dp_write_reg;
    logic [1:0]  dp_kind_reg;
    logic [31:0] dp_wdata_reg;
    logic        in_burst_reg;
    logic [31:0] next_addr_reg;

    logic err_first, err_second, dp_done, addr_ok, abort;
    logic err_pend_reg;

    // Prefetches keep their follower; every other error drops it
    function automatic logic cbm_keeps_next(input logic [1:0] k);
        cbm_keeps_next = (k == 2'(CBM_KIND_INSTR));
    endfunction : cbm_keeps_next

    assign err_first  = dp_valid_reg && !bus.hready
                        && bus.hresp == `CBM_RESP_ERROR;
    // The second error cycle counts only after a first one was seen,
    // so a stray error code with ready high cannot drop a request
    assign err_second = err_pend_reg && dp_valid_reg && bus.hready
                        && bus.hresp == `CBM_RESP_ERROR;
    assign dp_done    = dp_valid_reg && bus.hready;
    // RULE_17 RULE_18 RULE_14: data errors drop the pending request
    assign abort      = err_second && !cbm_keeps_next(dp_kind_reg);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) err_pend_reg <= 1'b0;
        else          err_pend_reg <= err_first; // RULE_13
    end
    // RULE_10 RULE_11 RULE_19
    assign addr_ok    = !dp_valid_reg || bus.hready;
    // RULE_16: prefetch error keeps the request presented
    assign buf_pop    = buf_valid && addr_ok;

    function automatic logic [31:0] cbm_word(input logic [31:0] a);
        cbm_word = a & `CBM_ALIGN_MASK;
    endfunction : cbm_word

    ////////////////////////////////////////////////////////////////////
    // Address phase outputs; the buffer head is shown while untaken.
    // While a read burst waits in its data phase and its next beat has
    // not arrived, the stepped address is offered ahead.  Ready is low,
    // so it cannot be taken; it is withdrawn or replaced by whatever
    // arrives next, burst or single.  Writes are never offered ahead,
    // so a presented write stands until it is taken or abort drops it.
    logic        cont_beat;
    logic        ahead;
    logic [31:0] beat_addr;

    // RULE_03
    assign cont_beat = in_burst_reg && head.burst;
    // RULE_07 RULE_08
    assign ahead     = !buf_valid && in_burst_reg && !dp_write_reg
                       && dp_valid_reg && !bus.hready;
    assign beat_addr = cont_beat ? next_addr_reg : cbm_word(head.addr);

    always_comb begin
        bus.htrans   = `CBM_TRANS_IDLE; // RULE_20
        bus.haddr    = beat_addr;
        bus.hwrite   = head.write;
        bus.hsize    = `CBM_SIZE_WORD; // RULE_01
        bus.hbstrb   = `CBM_STRB_ALL; // RULE_01
        bus.hunalign = 1'b0; // RULE_01
        bus.hburst   = head.burst ? `CBM_BURST_INCR // RULE_02
                                  : `CBM_BURST_SINGLE;
        if (buf_valid && !abort) begin
            // RULE_05 RULE_04 RULE_09
            bus.htrans = cont_beat ? `CBM_TRANS_SEQ : `CBM_TRANS_NONSEQ;
        end else if (ahead) begin
            // RULE_07: untaken read beat, replaceable
            bus.htrans = `CBM_TRANS_SEQ;
            bus.haddr  = next_addr_reg;
            bus.hwrite = 1'b0;
            bus.hburst = `CBM_BURST_INCR; // RULE_02
        end
    end
    assign bus.hwdata = dp_wdata_reg; // RULE_06

    logic issue;
    assign issue = buf_pop && !abort;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_valid_reg  <= 1'b0;
            dp_write_reg  <= 1'b0;
            dp_kind_reg   <= 2'h0;
            dp_wdata_reg  <= 32'h0;
            in_burst_reg  <= 1'b0;
            next_addr_reg <= 32'h0;
        end else begin
            if (addr_ok) dp_valid_reg <= issue;
            if (issue) begin
                dp_write_reg  <= head.write;
                dp_kind_reg   <= head.kind;
                dp_wdata_reg  <= head.wdata;
                in_burst_reg  <= head.burst && !head_last;
                next_addr_reg <= beat_addr + `CBM_WORD_STEP; // RULE_03
            end else if (buf_pop) begin
                in_burst_reg  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Completion report
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_valid_o <= 1'b0;
            done_rdata_o <= 32'h0;
            done_error_o <= 1'b0;
        end else begin
            done_valid_o <= dp_done;
            done_error_o <= err_second;
            // RULE_15: no read data is taken on an error
            if (dp_done && !dp_write_reg && !err_second)
                done_rdata_o <= bus.hrdata;
            else if (dp_done)
                done_rdata_o <= 32'h0;
        end
    end

endmodule : cbm_master

/* File: cbm_params.svh */
`ifndef CBM_PARAMS_SVH
`define CBM_PARAMS_SVH
// Transfer type codes
`define CBM_TRANS_IDLE    2'h0
`define CBM_TRANS_BUSY    2'h1
`define CBM_TRANS_NONSEQ  2'h2
`define CBM_TRANS_SEQ     2'h3
// Burst and size codes
`define CBM_BURST_SINGLE  3'h0
`define CBM_BURST_INCR    3'h1
`define CBM_SIZE_WORD     3'h2
// Response codes
`define CBM_RESP_OKAY     3'h0
`define CBM_RESP_ERROR    3'h1
// Word step, alignment mask and strobes
`define CBM_WORD_STEP     32'h4
`define CBM_ALIGN_MASK    32'hffff_fffc
`define CBM_STRB_ALL      4'hf
`endif

/* File: cbm_pkg.sv */
/*
 Types shared by both ends of the core bus link.
 Assumes cbm_params.svh is on the include path.
*/
package cbm_pkg;
    typedef enum logic [2:0] {
        CBM_KIND_INSTR = 3'h1,
        CBM_KIND_DATA  = 3'h2,
        CBM_KIND_SPLIT = 3'h4
    } cbm_kind_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic        burst;
        logic [1:0]  kind;
        logic [31:0] wdata;
    } cbm_req_t;
endpackage : cbm_pkg

/* File: cbm_props.sv */
/*
 Concurrent checks on the cbm_if link between master and slave.
 Assumes the testbench wires it beside the interface instance.
*/
`timescale 1ns/1ps
`include "cbm_params.svh"
module cbm_props (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    // Link signals
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [2:0]  hburst,
    input wire logic [3:0]  hbstrb,
    input wire logic        hunalign,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hready,
    input wire logic [2:0]  hresp
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    sequence err_one_s;
        hresp == `CBM_RESP_ERROR && !hready;
    endsequence
    sequence err_two_s;
        hresp == `CBM_RESP_ERROR && hready;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    burst_shape_a: assert property (
        htrans[1] && hburst == `CBM_BURST_INCR |-> hsize == `CBM_SIZE_WORD
        && hbstrb == `CBM_STRB_ALL && !hunalign) else $error("bad beat");
    burst_type_a: assert property (
        htrans[1] && hburst != `CBM_BURST_SINGLE |->
        hburst == `CBM_BURST_INCR) else $error("bad burst type");
    burst_align_a: assert property (
        htrans[1] && hburst == `CBM_BURST_INCR |-> haddr[1:0] == 2'h0)
        else $error("burst unaligned");
    beat_step_a: assert property (
        htrans == `CBM_TRANS_SEQ && $past(htrans[1]) && $past(hready) |->
        haddr == $past(haddr) + `CBM_WORD_STEP) else $error("bad step");
    // Writes may only move in the second error cycle
    write_hold_a: assert property (
        htrans[1] && hwrite && !hready && hresp != `CBM_RESP_ERROR |=>
        $stable(haddr) && $stable(htrans) && hwrite) else $error("moved");
    err_seq_a: assert property (
        err_one_s |=> err_two_s) else $error("error not two cycles");
    err_start_a: assert property (
        err_two_s |-> $past(hresp) == `CBM_RESP_ERROR && !$past(hready))
        else $error("error without first cycle");
    reset_idle_a: assert property (
        disable iff (1'b0)
        !rst_n_i || $rose(rst_n_i) |-> htrans == `CBM_TRANS_IDLE)
        else $error("busy in reset");
endmodule : cbm_props

/* File: cbm_slave.sv */
/*
 Bus slave end: a word memory that answers pipelined transfers, with
 configurable wait states and error injection.
 Assumes the master keeps one transfer outstanding.
*/
`timescale 1ns/1ps
`include "cbm_params.svh"
module cbm_slave #(
    parameter int WORDS = 256
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Control
    input  wire logic        wait_i,
    input  wire logic        error_i,
    // Bus
    cbm_if.slave             bus
);
    import cbm_pkg::*;

    localparam int AW = $clog2(WORDS);
    initial begin
        if (WORDS < 2) $error("cbm_slave: WORDS too small");
    end

    logic [31:0] mem [0:WORDS-1];
    typedef enum logic [3:0] {
        CBM_S_IDLE = 4'h1,
        CBM_S_WAIT = 4'h2,
        CBM_S_ERR1 = 4'h4,
        CBM_S_ERR2 = 4'h8
    } cbm_sstate_t;

    cbm_sstate_t state_reg, state_next;
    logic        act_reg, wr_reg, taken;
    logic [AW-1:0] idx_reg;

    // RULE_10 RULE_11: take on idle bus or when ready completes
    assign taken = bus.htrans[1] && bus.hready;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CBM_S_IDLE: if (taken) state_next = error_i ? CBM_S_ERR1
                                       : (wait_i ? CBM_S_WAIT : CBM_S_IDLE);
            CBM_S_WAIT: state_next = CBM_S_IDLE;
            CBM_S_ERR1: state_next = CBM_S_ERR2; // RULE_13
            CBM_S_ERR2: if (taken) state_next = wait_i ? CBM_S_WAIT
                                                       : CBM_S_IDLE;
                        else state_next = CBM_S_IDLE;
            default:    state_next = CBM_S_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) state_reg <= CBM_S_IDLE;
        else          state_reg <= state_next;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_reg <= 1'b0;
            wr_reg  <= 1'b0;
            idx_reg <= '0;
        end else if (bus.hready) begin
            act_reg <= taken;
            wr_reg  <= bus.hwrite;
            idx_reg <= bus.haddr[AW+1:2];
        end
    end

    always_comb begin
        bus.hready = (state_reg != CBM_S_WAIT) && (state_reg != CBM_S_ERR1);
        bus.hresp  = (state_reg == CBM_S_ERR1 || state_reg == CBM_S_ERR2)
                     ? `CBM_RESP_ERROR : `CBM_RESP_OKAY; // RULE_13
    end
    // RULE_12: read data in the data phase
    assign bus.hrdata = mem[idx_reg];

    always_ff @(posedge clock_i) begin
        if (act_reg && wr_reg && bus.hready && state_reg == CBM_S_IDLE)
            mem[idx_reg] <= bus.hwdata;
    end
endmodule : cbm_slave

/* File: test_cbm_master.sv */
/*
 Self-checking bench: master and slave joined by cbm_if, memory model.
 Assumes the package, header and design modules are compiled first.
*/
`timescale 1ns/1ps
`include "cbm_params.svh"
module test_cpu_bus_master_interface;
    import cbm_pkg::*;
    typedef struct { bit w; logic [31:0] d; } cbm_exp_t;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic        req_ready_o;
    cbm_req_t    req_i = '0;
    logic        req_last_i = 1'b0;
    logic        done_valid_o;
    logic [31:0] done_rdata_o;
    logic        done_error_o;
    logic        wait_i = 1'b0;
    logic        error_i = 1'b0;
    int          errors = 0;
    int          checks_done = 0;
    int          b, n, err_seen;
    bit          lax = 1'b0;
    logic [31:0] mem [int];
    cbm_exp_t    exp_q [$];
    cbm_if bus_if ();
    always #5 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////////////
    cbm_master cbm_master_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_i(req_i), .req_last_i(req_last_i),
        .done_valid_o(done_valid_o), .done_rdata_o(done_rdata_o),
        .done_error_o(done_error_o), .bus(bus_if.master));
    cbm_slave #(.WORDS(64)) cbm_slave_inst (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .wait_i(wait_i), .error_i(error_i),
        .bus(bus_if.slave));
    cbm_props cbm_props_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .haddr(bus_if.haddr), .htrans(bus_if.htrans),
        .hwrite(bus_if.hwrite), .hsize(bus_if.hsize),
        .hburst(bus_if.hburst), .hbstrb(bus_if.hbstrb),
        .hunalign(bus_if.hunalign), .hwdata(bus_if.hwdata),
        .hrdata(bus_if.hrdata), .hready(bus_if.hready),
        .hresp(bus_if.hresp));
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // Held until the buffer takes it; unless lax, the model is booked up front
    task automatic send(input logic [31:0] a, input logic w,
        input logic bu, input logic [1:0] k, input logic [31:0] d,
        input logic l);
        int t;
        t = 0;
        if (!lax && w) mem[a] = d;
        if (!lax) exp_q.push_back('{w, w ? 32'h0 : mem[a]});
        req_valid_i <= 1'b1;
        req_i <= '{addr: a, write: w, burst: bu, kind: k, wdata: d};
        req_last_i <= l;
        do begin
            @(posedge clock_i);
            t++;
        end while (req_ready_o !== 1'b1 && t < 200);
        if (t >= 200) begin
            errors++;
            finish_test();
        end
    endtask : send
    task automatic drain;
        int t;
        t = 0;
        req_valid_i <= 1'b0;
        while ((exp_q.size() != 0 || lax) && t < 1000) begin
            @(posedge clock_i);
            t++;
            if (lax && err_seen > 0 && t > 8) lax = 1'b0;
        end
        if (t >= 1000) begin
            errors++;
            finish_test();
        end
        @(posedge clock_i);
    endtask : drain
    // Random gaps mid-burst let a waiting read burst offer a beat ahead
    task automatic burst(input logic w, input int base, input int len);
        for (int i = 0; i < len; i++) begin
            send(32'(base + i) << 2, w, 1'b1, 2'b10, $urandom, i == len - 1);
            if ($urandom % 3 == 0) begin
                req_valid_i <= 1'b0;
                repeat (2) @(posedge clock_i);
            end
        end
    endtask : burst
    // An error on the head transfer, with a write queued behind it
    task automatic err_case(input logic [1:0] k, input logic w);
        logic [31:0] d;
        d = $urandom;
        lax = 1'b1;
        err_seen = 0;
        error_i <= 1'b1;
        send(32'h40, w, 1'b0, k, d, 1'b1);
        send(32'h80, 1'b1, 1'b0, (k == 2'b00) ? 2'b00 : 2'b10, d, 1'b1);
        drain();
        check(32'(err_seen > 0), 32'h1);
        if (k == 2'b01) mem[32'h80] = d;
        send(32'h80, 1'b0, 1'b0, 2'b10, 32'h0, 1'b1);
        drain();
    endtask : err_case
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin : monitor
        cbm_exp_t e;
        wait_i <= ($urandom % 3) == 0;
        if (bus_if.hresp == `CBM_RESP_ERROR && !bus_if.hready)
            error_i <= 1'b0;
        if (done_valid_o === 1'b1 && lax) begin
            if (done_error_o === 1'b1) err_seen++;
        end else if (done_valid_o === 1'b1 && exp_q.size() == 0) begin
            check(32'h1, 32'h0);
        end else if (done_valid_o === 1'b1) begin
            e = exp_q.pop_front();
            check({31'h0, done_error_o}, 32'h0);
            if (!e.w) check(done_rdata_o, e.d);
        end
    end
    initial begin
        void'($urandom(39));
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        for (int i = 0; i < 16; i++) begin
            b = $urandom % 48;
            n = 1 + $urandom % 8;
            burst(1'b1, b, n);
            burst(1'b0, b, n);
            send(32'(b) << 2, 1'b0, 1'b0, 2'(1 + $urandom % 2), 32'h0,
                1'b1);
            drain();
        end
        send(32'h80, 1'b1, 1'b0, 2'b10, 32'h0, 1'b1);
        drain();
        err_case(2'b10, 1'b0);
        err_case(2'b01, 1'b0);
        err_case(2'b00, 1'b1);
        finish_test();
    end
endmodule : test_cpu_bus_master_interface
